// ==== core/clock_gen_i2c_config_regs.v ====
// I2C target and configuration bank of a PLL clock generator.
// Assumes SCL/SDA are open-drain with external pull-ups; all pins are
// asynchronous to ref_clk and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_i2c_config_regs.vh"

// Behaviour
// - Answer address 110000 plus address-select level; R/W bit follows.
// - Write: address, pointer, acked data bytes to successive addresses.
// - Read: address, pointer byte, bytes returned from pointer onward.
// - Defaults from four strap pins at power-up and master reset release.
// - Divider writes take effect only once margin enable is already set.
// - Enabled spread spectrum blocks host programming of dividers.
// - Byte 0 holds bank A/B divider bits 6..1, default 0x1e.
// - Byte 1 holds bank C divider bits 6..1, default 0x1e.
// - Feedback divider split: byte 2 bits 10..3, byte 3 top bits 2..0.
// - Feedback divides by programmed value, kept within 4 to 1023.
// - Byte 3 bit 4 is margin enable; bits 3..2 reserved.
// - Disable bits: byte 3 bits 1..0, byte 4 bits 7..4, writable except while master reset is high.
// - A set disable bit forces its output off regardless of pin.
// - Output on only when pin allows and disable bit clear.
// - Spread blocks feedback and output divider writes alike.
module clock_gen_i2c_config_regs (
  input wire ref_clk,
  input wire resetn,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  input wire addr_select_pin,
  input wire [3:0] freq_select_straps,
  input wire master_reset_pin,
  input wire spread_enable_pin,
  input wire ref_output_enable_pin,
  input wire bank_c_output_enable_pin,
  output reg [6:0] bank_ab_divider,
  output reg [6:0] bank_c_divider,
  output reg [10:0] feedback_divider,
  output reg margin_enable,
  output reg ref_out_zero_on,
  output reg ref_out_one_on,
  output reg [3:0] bank_c_out_on
);

  // ==========================================================
  // Pin synchronisation
  // Address select is a pin too, so it is synchronised like the straps
  wire [10:0] pins_s;
  sync2 #(
    .WIDTH(11),
    .RESET_VALUE(11'h003)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in({addr_select_pin, bank_c_output_enable_pin,
               ref_output_enable_pin,
               spread_enable_pin, master_reset_pin, freq_select_straps,
               sda_in, scl_in}),
    .sync_out(pins_s)
  );
  wire scl_s = pins_s[0];
  wire sda_s = pins_s[1];
  wire [3:0] straps_s = pins_s[5:2];
  wire mr_s = pins_s[6];
  wire spread_s = pins_s[7];
  wire ref_oe_s = pins_s[8];
  wire c_oe_s = pins_s[9];
  wire addr_sel_s = pins_s[10];

  // ==========================================================
  // Strap defaults
  wire [6:0] dflt_ab;
  wire [6:0] dflt_c;
  wire [10:0] dflt_fb;
  strap_defaults u_straps (
    .freq_select_straps(straps_s),
    .dflt_bank_ab_divider(dflt_ab),
    .dflt_bank_c_divider(dflt_c),
    .dflt_feedback_divider(dflt_fb)
  );

  // Straps need the synchroniser to fill before they are trusted
  reg [1:0] settle_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      settle_q <= 2'h0;
    end else if (settle_q != `STRAP_SETTLE_CYCLES) begin
      settle_q <= settle_q + 2'h1;
    end
  end
  // Held defaults while master reset is high, so release leaves them
  wire load_dflt = (settle_q != `STRAP_SETTLE_CYCLES) | mr_s;

  // ==========================================================
  // Bus edge detection on synchronised lines
  reg scl_prev_q;
  reg sda_prev_q;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ==========================================================
  // Target state machine
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_ACK = 7'h04;
  localparam [6:0] ST_PTR = 7'h08;
  localparam [6:0] ST_WDATA = 7'h10;
  localparam [6:0] ST_RDATA = 7'h20;
  localparam [6:0] ST_RACK = 7'h40;

  reg [6:0] state_q;
  reg [6:0] after_ack_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg [7:0] byte_pointer;
  reg rw_q;
  reg host_nack_q;

  // Register storage
  reg [5:0] ab_div_q;
  reg [5:0] c_div_q;
  reg [10:0] fb_div_q;
  reg margin_q;
  reg [1:0] ref_dis_q;
  reg [3:0] c_dis_q;

  reg [7:0] rd_data;
  always @* begin
    case (byte_pointer)
      `REG_BANK_AB_OUT_DIVIDER: rd_data = {1'b0, ab_div_q, 1'b0};
      `REG_BANK_C_OUT_DIVIDER: rd_data = {1'b0, c_div_q, 1'b0};
      `REG_FEEDBACK_DIVIDER_HIGH: rd_data = fb_div_q[10:3];
      `REG_FEEDBACK_LOW_MARGIN_REF_CTRL:
        rd_data = {fb_div_q[2:0], margin_q, 2'h0, ref_dis_q};
      `REG_BANK_C_OUTPUT_DISABLES:
        rd_data = {c_dis_q, `C_DIS_RESERVED_VALUE};
      default: rd_data = 8'h00;
    endcase
  end

  wire addr_match = (shift_q[7:1] == {`TGT_ADDR_HIGH, addr_sel_s});
  wire byte_done = (bit_cnt_q == 4'h8);
  wire wr_strobe = scl_fall & (state_q == ST_WDATA) & byte_done;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      after_ack_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      byte_pointer <= 8'h00;
      rw_q <= 1'b0;
      host_nack_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      // Repeated start restarts address phase anywhere
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      state_q <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          shift_q <= {shift_q[6:0], sda_s};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        ST_RDATA: begin
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        ST_RACK: begin
          host_nack_q <= sda_s;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              rw_q <= shift_q[0];
              state_q <= ST_ACK;
              after_ack_q <= ST_PTR;
              sda_oe <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_PTR: begin
          if (byte_done) begin
            byte_pointer <= shift_q;
            state_q <= ST_ACK;
            after_ack_q <= rw_q ? ST_RDATA : ST_WDATA;
            sda_oe <= 1'b1;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            byte_pointer <= byte_pointer + 8'h01;
            state_q <= ST_ACK;
            after_ack_q <= ST_WDATA;
            sda_oe <= 1'b1;
          end
        end
        ST_ACK: begin
          bit_cnt_q <= 4'h0;
          state_q <= after_ack_q;
          if (after_ack_q == ST_RDATA) begin
            tx_q <= rd_data;
            byte_pointer <= byte_pointer + 8'h01;
            sda_oe <= ~rd_data[7];
          end else begin
            sda_oe <= 1'b0;
          end
        end
        ST_RDATA: begin
          if (byte_done) begin
            sda_oe <= 1'b0;
            state_q <= ST_RACK;
          end else begin
            sda_oe <= ~tx_q[3'h7 - bit_cnt_q[2:0]];
          end
        end
        ST_RACK: begin
          if (host_nack_q) begin
            // Host ends the read; wait for stop or start
            state_q <= ST_IDLE;
            sda_oe <= 1'b0;
          end else begin
            tx_q <= rd_data;
            byte_pointer <= byte_pointer + 8'h01;
            bit_cnt_q <= 4'h0;
            state_q <= ST_RDATA;
            sda_oe <= ~rd_data[7];
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_out = 1'b0;

  // ==========================================================
  // Register writes
  // Output dividers are blocked under spread too: the stricter reading,
  // so a spread profile never meets an unexpected divider.
  wire divider_ok = margin_q & ~spread_s;
  wire [7:0] wdata = shift_q;
  localparam [7:0] AB_RST = `RST_BANK_AB_OUT_DIVIDER;
  localparam [7:0] C_RST = `RST_BANK_C_OUT_DIVIDER;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ab_div_q <= AB_RST[`FLD_OUT_DIV_MSB:`FLD_OUT_DIV_LSB];
      c_div_q <= C_RST[`FLD_OUT_DIV_MSB:`FLD_OUT_DIV_LSB];
      fb_div_q <= `RST_FEEDBACK_DIVIDER;
      margin_q <= 1'b0;
      ref_dis_q <= 2'h0;
      c_dis_q <= 4'h0;
    end else if (load_dflt) begin
      ab_div_q <= dflt_ab[6:1];
      c_div_q <= dflt_c[6:1];
      fb_div_q <= dflt_fb;
      margin_q <= 1'b0;
      ref_dis_q <= 2'h0;
      c_dis_q <= 4'h0;
    end else if (wr_strobe) begin
      case (byte_pointer)
        `REG_BANK_AB_OUT_DIVIDER: begin
          if (divider_ok) begin
            ab_div_q <= wdata[`FLD_OUT_DIV_MSB:`FLD_OUT_DIV_LSB];
          end
        end
        `REG_BANK_C_OUT_DIVIDER: begin
          if (divider_ok) begin
            c_div_q <= wdata[`FLD_OUT_DIV_MSB:`FLD_OUT_DIV_LSB];
          end
        end
        `REG_FEEDBACK_DIVIDER_HIGH: begin
          if (divider_ok) begin
            fb_div_q[10:3] <= wdata;
          end
        end
        `REG_FEEDBACK_LOW_MARGIN_REF_CTRL: begin
          if (divider_ok) begin
            fb_div_q[2:0] <= wdata[`FLD_FB_LOW_MSB:`FLD_FB_LOW_LSB];
          end
          margin_q <= wdata[`FLD_MARGIN_ENABLE];
          ref_dis_q <= wdata[`FLD_REF_ONE_DIS:`FLD_REF_ZERO_DIS];
        end
        `REG_BANK_C_OUTPUT_DISABLES: begin
          c_dis_q <= wdata[`FLD_C_DIS_MSB:`FLD_C_DIS_LSB];
        end
        default: begin
          // Reserved addresses swallow the byte
        end
      endcase
    end
  end

  // ==========================================================
  // Effective settings towards the PLL and output drivers
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bank_ab_divider <= 7'h00;
      bank_c_divider <= 7'h00;
      feedback_divider <= `RST_FEEDBACK_DIVIDER;
      margin_enable <= 1'b0;
      ref_out_zero_on <= 1'b0;
      ref_out_one_on <= 1'b0;
      bank_c_out_on <= 4'h0;
    end else begin
      bank_ab_divider <= {ab_div_q, 1'b0};
      bank_c_divider <= {c_div_q, 1'b0};
      // Out-of-range codes are pinned to the nearest legal divide
      if (fb_div_q < `FB_DIV_MIN) begin
        feedback_divider <= `FB_DIV_MIN;
      end else if (fb_div_q > `FB_DIV_MAX) begin
        feedback_divider <= `FB_DIV_MAX;
      end else begin
        feedback_divider <= fb_div_q;
      end
      margin_enable <= margin_q;
      // Master reset does not gate the reference outputs; it clears their disable bits
      ref_out_zero_on <= ref_oe_s & ~ref_dis_q[0];
      ref_out_one_on <= ref_oe_s & ~ref_dis_q[1];
      bank_c_out_on <= {4{c_oe_s & ~mr_s}} & ~c_dis_q;
    end
  end

endmodule // clock_gen_i2c_config_regs

`default_nettype wire

// ==== core/strap_defaults.v ====
// Strap-to-default decode for the divider registers.
// Assumes straps already synchronised to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module strap_defaults #(
  // Output divider per frequency code 66.67/100/125/66.67 MHz
  parameter [6:0] DIV_CODE0 = 7'h1e,
  parameter [6:0] DIV_CODE1 = 7'h14,
  parameter [6:0] DIV_CODE2 = 7'h10,
  parameter [6:0] DIV_CODE3 = 7'h1e,
  parameter [10:0] FB_DEFAULT = 11'h280
) (
  input wire [3:0] freq_select_straps,
  output reg [6:0] dflt_bank_ab_divider,
  output reg [6:0] dflt_bank_c_divider,
  output wire [10:0] dflt_feedback_divider
);

  function [6:0] code_to_div;
    input [1:0] code;
    begin
      case (code)
        2'h0: code_to_div = DIV_CODE0;
        2'h1: code_to_div = DIV_CODE1;
        2'h2: code_to_div = DIV_CODE2;
        default: code_to_div = DIV_CODE3;
      endcase
    end
  endfunction

  // Upper straps pick banks A/B, lower straps pick bank C
  always @* begin
    dflt_bank_ab_divider = code_to_div(freq_select_straps[3:2]);
    dflt_bank_c_divider = code_to_div(freq_select_straps[1:0]);
  end

  assign dflt_feedback_divider = FB_DEFAULT;

endmodule // strap_defaults

`default_nettype wire

// ==== core/sync2.v ====
// Two-flop synchroniser, one stage pair per bit.
// Assumes asynchronous inputs; outputs are in the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire ref_clk,
  input wire resetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg stable_q;
      always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          meta_q <= RESET_VALUE[i];
          stable_q <= RESET_VALUE[i];
        end else begin
          meta_q <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule // sync2

`default_nettype wire

// ==== dv/clock_gen_cfg_properties.sv ====
// Port checker for the clock generator configuration bank.
// Assumes straps change only together with master reset being raised.
`timescale 1ns/1ps
`default_nettype none
module clock_gen_cfg_properties (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic addr_select_pin,
  input wire logic [3:0] freq_select_straps,
  input wire logic master_reset_pin,
  input wire logic spread_enable_pin,
  input wire logic ref_output_enable_pin,
  input wire logic bank_c_output_enable_pin,
  input wire logic [6:0] bank_ab_divider,
  input wire logic [6:0] bank_c_divider,
  input wire logic [10:0] feedback_divider,
  input wire logic margin_enable,
  input wire logic ref_out_zero_on,
  input wire logic ref_out_one_on,
  input wire logic [3:0] bank_c_out_on
);
  // ==========================================================
  // Strap decode: codes give 30, 20, 16, 30
  function automatic logic [6:0] dflt(input logic [1:0] c);
    case (c)
      2'h1: dflt = 7'h14;
      2'h2: dflt = 7'h10;
      default: dflt = 7'h1e;
    endcase
  endfunction
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Properties
  sda_low_only_a: assert property (sda_out == 1'b0)
    else $error("sda_out not tied low");
  oe_in_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda_oe moved while scl high");
  fb_in_range_a: assert property (
    feedback_divider >= 11'h004 && feedback_divider <= 11'h3ff)
    else $error("feedback divider out of range");
  out_div_even_a: assert property (
    !bank_ab_divider[0] && !bank_c_divider[0])
    else $error("odd output divider");
  ref_pin_off_a: assert property (
    !ref_output_enable_pin [*8] |-> !ref_out_zero_on && !ref_out_one_on)
    else $error("ref output on with pin low");
  c_pin_off_a: assert property (
    (!bank_c_output_enable_pin || master_reset_pin) [*8]
      |-> bank_c_out_on == 4'h0)
    else $error("bank c output on while blocked");
  strap_load_a: assert property (
    master_reset_pin [*8] |-> !margin_enable
      && feedback_divider == 11'h280
      && bank_ab_divider == dflt(freq_select_straps[3:2])
      && bank_c_divider == dflt(freq_select_straps[1:0]))
    else $error("strap defaults not held");
  no_margin_hold_a: assert property (
    (!margin_enable && !master_reset_pin) [*8]
      |=> $stable(bank_ab_divider) && $stable(bank_c_divider))
    else $error("divider moved without margin");
  spread_hold_a: assert property (
    (spread_enable_pin && !master_reset_pin) [*8]
      |=> $stable(feedback_divider) && $stable(bank_ab_divider)
        && $stable(bank_c_divider))
    else $error("divider moved under spread");
endmodule // clock_gen_cfg_properties
`default_nettype wire

// ==== dv/i2c_host_model.sv ====
// I2C controller model: drives SCL and pulls SDA low on request.
// Assumes an external pull-up, so a released SDA reads high.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  output logic scl,
  output logic sda_pull,
  input wire logic sda_wire
);
  // ==========================================================
  // Frames at 160 ns per bit; SCL stands high between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic start_cond();
    #40 sda_pull = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic stop_cond();
    #40 sda_pull = 1'b1;
    #40 scl = 1'b1;
    #80 sda_pull = 1'b0;
    #80;
  endtask
  // Data set mid low phase, well ahead of the SCL rise
  task automatic bit_out(input logic b);
    #40 sda_pull = ~b;
    #40 scl = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    #40 sda_pull = 1'b0;
    #40 scl = 1'b1;
    #40 b = sda_wire;
    #40 scl = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = ~b;
  endtask
  // Last byte of a read is answered with NACK
  task automatic recv_byte(output logic [7:0] d, input logic last);
    logic b;
    for (int i = 0; i < 8; i++) begin
      bit_in(b);
      d = {d[6:0], b};
    end
    bit_out(last);
  endtask
endmodule // i2c_host_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the clock generator configuration bank.
// Assumes the I2C host model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_i2c_config_regs.vh"
module tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic addr_select_pin = 1'b1;
  logic [3:0] freq_select_straps = 4'h6;
  logic master_reset_pin = 1'b0;
  logic spread_enable_pin = 1'b0;
  logic ref_output_enable_pin = 1'b1;
  logic bank_c_output_enable_pin = 1'b1;
  logic scl, sda_pull, sda_oe, sda_out, margin_enable, ack_bit;
  logic ref_out_zero_on, ref_out_one_on;
  logic [6:0] bank_ab_divider, bank_c_divider;
  logic [10:0] feedback_divider;
  logic [3:0] bank_c_out_on;
  logic [7:0] rd [5];
  int bad_count = 0;
  int n_tests = 0;
  wire sda_wire = ~((sda_oe & ~sda_out) | sda_pull);
  wire [5:0] on_vec = {ref_out_zero_on, ref_out_one_on, bank_c_out_on};

  clock_gen_i2c_config_regs i_clock_gen_i2c_config_regs (
    .ref_clk, .resetn, .scl_in(scl), .sda_in(sda_wire), .sda_out, .sda_oe,
    .addr_select_pin, .freq_select_straps, .master_reset_pin,
    .spread_enable_pin, .ref_output_enable_pin, .bank_c_output_enable_pin,
    .bank_ab_divider, .bank_c_divider, .feedback_divider, .margin_enable,
    .ref_out_zero_on, .ref_out_one_on, .bank_c_out_on
  );
  i2c_host_model i_i2c_host_model (.scl, .sda_pull, .sda_wire);

  always #4 ref_clk = ~ref_clk;

  // ==========================================================
  // Checking and closing
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================
  // Register access over I2C: address, pointer, then data
  task automatic xfer(input logic rw, input logic [7:0] ptr,
                      input logic [7:0] wd [5], input int n);
    logic a;
    i_i2c_host_model.start_cond();
    i_i2c_host_model.send_byte({`TGT_ADDR_HIGH, addr_select_pin, rw}, a);
    check("address ack", a, 1'b1);
    i_i2c_host_model.send_byte(ptr, a);
    check("pointer ack", a, 1'b1);
    for (int i = 0; i < n; i++) begin
      if (rw)
        i_i2c_host_model.recv_byte(rd[i], i == n - 1);
      else begin
        i_i2c_host_model.send_byte(wd[i], a);
        check("data ack", a, 1'b1);
      end
    end
    i_i2c_host_model.stop_cond();
  endtask
  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] e [5],
                        input int n);
    xfer(1'b1, ptr, e, n);
    for (int i = 0; i < n; i++) check("register byte", rd[i], e[i]);
  endtask
  task automatic out_chk(input logic [6:0] ab, c, input logic [10:0] fb,
                         input logic m);
    check("bank ab divider", bank_ab_divider, ab);
    check("bank c divider", bank_c_divider, c);
    check("feedback divider", feedback_divider, fb);
    check("margin enable", margin_enable, m);
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 resetn = 1'b1;
    repeat (12) @(posedge ref_clk);
    #1;
    rd_chk(8'h00, '{8'h14, 8'h10, 8'h50, 8'h00, 8'h0b}, 5);
    out_chk(7'h14, 7'h10, 11'h280, 1'b0);
    check("outputs on", on_vec, 6'h3f);
    i_i2c_host_model.start_cond();
    i_i2c_host_model.send_byte({`TGT_ADDR_HIGH, ~addr_select_pin, 1'b0},
                               ack_bit);
    check("foreign address ack", ack_bit, 1'b0);
    i_i2c_host_model.stop_cond();
    // Divider bytes refused until margin is on
    xfer(1'b0, 8'h00, '{8'h20, 8'h20, 8'h70, 8'h00, 8'h00}, 3);
    out_chk(7'h14, 7'h10, 11'h280, 1'b0);
    xfer(1'b0, 8'h03, '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    xfer(1'b0, 8'h00,
         '{8'h9b, 8'h30, 8'h58, 8'hbc, 8'h00}, 4);
    out_chk(7'h1a, 7'h30, 11'h2c5, 1'b1);
    rd_chk(8'h00, '{8'h1a, 8'h30, 8'h58, 8'hb0, 8'h0b}, 5);
    // Disable bits, with a write past the last register
    xfer(1'b0, 8'h03, '{8'hb3, 8'ha5, 8'hff, 8'h00, 8'h00}, 3);
    check("outputs on", on_vec, 6'h05);
    rd_chk(8'h03, '{8'hb3, 8'hab, 8'h00, 8'h00, 8'h00}, 3);
    bank_c_output_enable_pin = 1'b0;
    xfer(1'b0, 8'h04, '{8'h0b, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    check("outputs on", on_vec, 6'h00);
    bank_c_output_enable_pin = 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 check("outputs on", on_vec, 6'h0f);
    // Spread blocks both divider kinds
    spread_enable_pin = 1'b1;
    xfer(1'b0, 8'h00, '{8'h40, 8'h40, 8'h60, 8'h13, 8'h00}, 4);
    out_chk(7'h1a, 7'h30, 11'h2c5, 1'b1);
    spread_enable_pin = 1'b0;
    // Master reset reloads strap defaults
    freq_select_straps = 4'h0;
    master_reset_pin = 1'b1;
    repeat (20) @(posedge ref_clk);
    #1 check("outputs on", on_vec, 6'h30);
    ref_output_enable_pin = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 check("outputs on", on_vec, 6'h00);
    ref_output_enable_pin = 1'b1;
    master_reset_pin = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1 out_chk(7'h1e, 7'h1e, 11'h280, 1'b0);
    rd_chk(8'h00, '{8'h1e, 8'h1e, 8'h50, 8'h00, 8'h0b}, 5);
    tally_and_finish();
  end
endmodule // tb_top

bind clock_gen_i2c_config_regs clock_gen_cfg_properties
  i_clock_gen_cfg_properties (
  .ref_clk, .resetn, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_select_pin,
  .freq_select_straps, .master_reset_pin, .spread_enable_pin,
  .ref_output_enable_pin, .bank_c_output_enable_pin, .bank_ab_divider,
  .bank_c_divider, .feedback_divider, .margin_enable, .ref_out_zero_on,
  .ref_out_one_on, .bank_c_out_on
);
`default_nettype wire

// ==== shared/clock_gen_i2c_config_regs.vh ====
// Constants for the clock generator I2C configuration bank.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef CLOCK_GEN_I2C_CONFIG_REGS_VH
`define CLOCK_GEN_I2C_CONFIG_REGS_VH

// ==========================================================
// Target address
`define TGT_ADDR_HIGH 6'h30

// ==========================================================
// Register byte addresses
`define REG_BANK_AB_OUT_DIVIDER 8'h00
`define REG_BANK_C_OUT_DIVIDER 8'h01
`define REG_FEEDBACK_DIVIDER_HIGH 8'h02
`define REG_FEEDBACK_LOW_MARGIN_REF_CTRL 8'h03
`define REG_BANK_C_OUTPUT_DISABLES 8'h04

// ==========================================================
// Reset values
`define RST_BANK_AB_OUT_DIVIDER 8'h1e
`define RST_BANK_C_OUT_DIVIDER 8'h1e
`define RST_FEEDBACK_DIVIDER_HIGH 8'h50
`define RST_FEEDBACK_LOW_MARGIN_REF_CTRL 8'h00
`define RST_BANK_C_OUTPUT_DISABLES 8'h0b
`define RST_FEEDBACK_DIVIDER 11'h280

// ==========================================================
// Field positions
`define FLD_OUT_DIV_MSB 6
`define FLD_OUT_DIV_LSB 1
`define FLD_FB_LOW_MSB 7
`define FLD_FB_LOW_LSB 5
`define FLD_MARGIN_ENABLE 4
`define FLD_REF_ONE_DIS 1
`define FLD_REF_ZERO_DIS 0
`define FLD_C_DIS_MSB 7
`define FLD_C_DIS_LSB 4
`define C_DIS_RESERVED_VALUE 4'hb

// ==========================================================
// Feedback divider limits
`define FB_DIV_MIN 11'h004
`define FB_DIV_MAX 11'h3ff

// ==========================================================
// Timing counts (ref_clk cycles)
`define STRAP_SETTLE_CYCLES 2'h3

`endif
